// >>> include/aeo_pkg.sv
package aeo_pkg;

  // Code width and limits
  localparam int unsigned CODE_W       = 12;
  localparam logic [11:0] OB_MAX       = 12'h0_FFF;
  localparam logic [11:0] OB_MIN       = 12'h0_000;
  localparam logic [11:0] OB_ZERO      = 12'h0_800;
  localparam logic [11:0] TC_MAX       = 12'h0_7FF;
  localparam logic [11:0] TC_MIN       = 12'h0_800;
  localparam logic [11:0] TC_ZERO      = 12'h0_000;
  localparam logic [11:0] SIGN_FLIP    = 12'h0_800;

  // Pipeline depth and stabilizer relock
  localparam int unsigned PIPE_DEPTH   = 5;
  localparam int unsigned RELOCK_CYC   = 100;
  localparam logic [7:0]  RELOCK_CNT_W = 8'h00;
  localparam logic [7:0]  RELOCK_LAST  = 8'h64;

  // Encode rate limits kept by the clock source
  localparam int unsigned ENC_MAX_MSPS = 250;
  localparam int unsigned ENC_MIN_MSPS = 1;
  localparam int unsigned HALF_MIN_PS  = 1900;

  // Clock and stop detection
  localparam int unsigned CLK_SYS_MHZ  = 20;
  localparam int unsigned STOP_US      = 10;
  localparam int unsigned STOP_CYC     = STOP_US * CLK_SYS_MHZ;
  localparam logic [7:0]  STOP_LAST    = 8'(STOP_CYC);

  // Four-level mode strap
  typedef enum logic [1:0]
  {
    MODE_GND  = 2'b00,
    MODE_THR1 = 2'b01,
    MODE_THR2 = 2'b10,
    MODE_VDD  = 2'b11
  } aeo_mode_t;

  typedef enum logic [1:0]
  {
    ST_RUN    = 2'b00,
    ST_RELOCK = 2'b01,
    ST_STOP   = 2'b10
  } aeo_state_t;

  // One conversion result in flight
  typedef struct packed
  {
    logic              vld;
    logic              ovr;
    logic              neg;
    logic [11:0]       raw;
  } aeo_smp_t;

  typedef struct packed
  {
    logic [2:0]        enc_sync;
    logic [2:0][1:0]   mode_sync;
    logic              enc_prev;
    logic              enc_hi;
    logic [7:0]        phase_cnt;
    logic [7:0]        half_cnt;
    logic              int_clk;
    logic [7:0]        stop_cnt;
    logic [7:0]        relock_cnt;
    aeo_state_t        state;
    aeo_smp_t [4:0]    pipe;
    logic [11:0]       code;
    logic              ovr_flag;
    logic              code_vld;
    logic              sample_edge;
    logic              dcs_on;
    logic              twos;
  } aeo_st_t;

endpackage

// >>> rtl/aeo_top.sv
`timescale 1ns/1ps
// Behaviour
// - Offset binary: all ones top, all zeros bottom, 0x800 at zero input.
// - Two's complement: 0x7FF top, 0x800 bottom, zero at zero input.
// - Out-of-range raises the flag and saturates the code; else flag low.
// - Stabilizer on: sample on rising edge, internal falling edge regenerated.
// - Stabilizer on: accepts 40-60% duty, internal clock kept at 50%.
// - After a long clock stop with stabilizer on, one hundred cycles relock; samples marked invalid.
// - Stabilizer only at the one-third or two-thirds strap levels.
// - Result appears five encode cycles after its sampling edge.
// - Input captured on encode rising edge, held while encode high.
// - Offset binary at ground or one third; two's complement otherwise.
module aeo_top
  import aeo_pkg::*;
#(
  parameter int unsigned DEPTH = PIPE_DEPTH
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Encode clock pin, sampled
  input  wire logic        encode_clock_pos,
  // Format and stabilizer strap
  input  wire logic [1:0]  mode_sel,
  // Analog front end result at the hold instant
  input  wire logic [11:0] conv_raw,
  input  wire logic        conv_over,
  input  wire logic        conv_under,
  // Output word
  output logic [11:0]      sample_code_bits,
  output logic             out_of_range_flag,
  output logic             sample_valid,
  output logic             internal_clock,
  output logic             stabilizer_on
);

  aeo_st_t s_q;
  aeo_st_t s_d;

  function automatic logic [11:0] enc_code(input logic [11:0] raw, input logic twos);
    enc_code = twos ? (raw ^ SIGN_FLIP) : raw;
  endfunction

  function automatic logic dcs_of(input logic [1:0] m);
    dcs_of = (m == MODE_THR1) || (m == MODE_THR2);
  endfunction

  logic rise;
  logic fall;
  assign rise = s_q.enc_sync[2] & s_q.enc_sync[1] & ~s_q.enc_prev;
  assign fall = ~s_q.enc_sync[2] & ~s_q.enc_sync[1] & s_q.enc_prev;

  always_comb
  begin
    s_d = s_q;
    s_d.enc_sync = {s_q.enc_sync[1:0], encode_clock_pos};
    if (s_q.enc_sync[2] == s_q.enc_sync[1])
    begin
      s_d.enc_prev = s_q.enc_sync[1];
    end
    // Strap pin synchroniser, decoded once two stages agree
    s_d.mode_sync = {s_q.mode_sync[1:0], mode_sel};
    if (s_q.mode_sync[2] == s_q.mode_sync[1])
    begin
      s_d.dcs_on = dcs_of(s_q.mode_sync[1]);
      s_d.twos = s_q.mode_sync[1][1];
    end
    s_d.sample_edge = 1'b0;
    // Stop detection on the encode pin
    if (rise | fall)
    begin
      s_d.stop_cnt = 8'h00;
    end
    else if (s_q.stop_cnt != STOP_LAST)
    begin
      s_d.stop_cnt = s_q.stop_cnt + 8'h01;
    end
    // Period tracking and internal clock phase
    if (rise)
    begin
      s_d.phase_cnt = 8'h01;
      s_d.half_cnt = s_q.phase_cnt >> 1;
    end
    else if (s_q.phase_cnt != 8'hFF)
    begin
      s_d.phase_cnt = s_q.phase_cnt + 8'h01;
    end
    if (s_q.dcs_on)
    begin
      if (rise)
      begin
        s_d.int_clk = 1'b1;
      end
      else if (s_q.int_clk && s_q.phase_cnt >= s_q.half_cnt)
      begin
        s_d.int_clk = 1'b0;
      end
    end
    else
    begin
      if (rise)
      begin
        s_d.int_clk = 1'b1;
      end
      else if (fall)
      begin
        s_d.int_clk = 1'b0;
      end
    end
    // Relock state
    case (s_q.state)
      ST_RUN:
      begin
        if (s_q.stop_cnt == STOP_LAST)
        begin
          s_d.state = ST_STOP;
        end
      end
      ST_STOP:
      begin
        if (rise)
        begin
          s_d.state = s_q.dcs_on ? ST_RELOCK : ST_RUN;
          s_d.relock_cnt = 8'h00;
        end
      end
      ST_RELOCK:
      begin
        if (s_q.stop_cnt == STOP_LAST)
        begin
          s_d.state = ST_STOP;
        end
        else if (rise)
        begin
          s_d.relock_cnt = s_q.relock_cnt + 8'h01;
          if (s_q.relock_cnt + 8'h01 == RELOCK_LAST)
          begin
            s_d.state = ST_RUN;
          end
        end
      end
      default:
      begin
        s_d.state = ST_STOP;
      end
    endcase
    // Capture and pipeline on each rising encode edge
    if (rise)
    begin
      s_d.sample_edge = 1'b1;
      s_d.pipe[0].raw = conv_raw;
      s_d.pipe[0].ovr = conv_over | conv_under;
      s_d.pipe[0].neg = conv_under;
      s_d.pipe[0].vld = (s_q.state == ST_RUN);
      for (int i = 1; i < 5; i++)
      begin
        s_d.pipe[i] = s_q.pipe[i-1];
      end
      // Output word and flag move together
      s_d.ovr_flag = s_q.pipe[4].ovr;
      s_d.code_vld = s_q.pipe[4].vld;
      if (s_q.pipe[4].ovr)
      begin
        s_d.code = s_q.pipe[4].neg ? (s_q.twos ? TC_MIN : OB_MIN)
                                   : (s_q.twos ? TC_MAX : OB_MAX);
      end
      else
      begin
        s_d.code = enc_code(s_q.pipe[4].raw, s_q.twos);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '{state: ST_STOP, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sample_code_bits  = s_q.code;
  assign out_of_range_flag = s_q.ovr_flag;
  assign sample_valid      = s_q.code_vld;
  assign internal_clock    = s_q.int_clk;
  assign stabilizer_on     = s_q.dcs_on;

  property p_sat_code;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(s_q.sample_edge) && s_q.ovr_flag |->
      ($past(s_q.twos) ? (s_q.code == TC_MAX || s_q.code == TC_MIN)
                       : (s_q.code == OB_MAX || s_q.code == OB_MIN));
  endproperty
  a_sat_code: assert property (p_sat_code) else $error("overflow code not saturated");

  property p_ob_zero;
    @(posedge clk_sys) disable iff (!rstn)
    rise && !s_q.pipe[4].ovr && !s_q.twos && s_q.pipe[4].raw == OB_ZERO |=>
      s_q.code == OB_ZERO;
  endproperty
  a_ob_zero: assert property (p_ob_zero) else $error("offset binary zero wrong");

  property p_tc_zero;
    @(posedge clk_sys) disable iff (!rstn)
    rise && !s_q.pipe[4].ovr && s_q.twos && s_q.pipe[4].raw == OB_ZERO |=>
      s_q.code == TC_ZERO;
  endproperty
  a_tc_zero: assert property (p_tc_zero) else $error("two's complement zero wrong");

  property p_hold;
    @(posedge clk_sys) disable iff (!rstn)
    !rise |=> $stable(s_q.code) && $stable(s_q.ovr_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed off an encode edge");

  property p_dcs_map;
    @(posedge clk_sys) disable iff (!rstn)
    s_q.mode_sync[2] == s_q.mode_sync[1] |=>
      s_q.dcs_on == dcs_of(s_q.mode_sync[2]);
  endproperty
  a_dcs_map: assert property (p_dcs_map) else $error("stabilizer strap decode wrong");

  property p_fmt_map;
    @(posedge clk_sys) disable iff (!rstn)
    s_q.mode_sync[2] == s_q.mode_sync[1] |=>
      s_q.twos == s_q.mode_sync[2][1];
  endproperty
  a_fmt_map: assert property (p_fmt_map) else $error("format strap decode wrong");

  property p_relock_invalid;
    @(posedge clk_sys) disable iff (!rstn)
    rise && s_q.state != ST_RUN |=> !s_q.pipe[0].vld;
  endproperty
  a_relock_invalid: assert property (p_relock_invalid) else $error("relock sample valid");

  property p_dcs_rise;
    @(posedge clk_sys) disable iff (!rstn)
    s_q.dcs_on && rise |=> s_q.int_clk;
  endproperty
  a_dcs_rise: assert property (p_dcs_rise) else $error("internal clock missed rise");

  property p_raw_direct;
    @(posedge clk_sys) disable iff (!rstn)
    !s_q.dcs_on && fall |=> !s_q.int_clk;
  endproperty
  a_raw_direct: assert property (p_raw_direct) else $error("falling edge not followed");

endmodule

// >>> verification/adc_encode_and_output_coding_tb_top.sv
`timescale 1ns/1ps
module adc_encode_and_output_coding_tb_top
  import aeo_pkg::*;
;
  logic        clk_sys;
  logic        rstn;
  logic        enc;
  logic [1:0]  mode_sel;
  logic [11:0] conv_raw;
  logic        conv_over;
  logic        conv_under;
  logic [11:0] code;
  logic        flag;
  logic        vld;
  logic        stab;
  logic        iclk;
  logic        run;
  logic [9:0]  hi_ns;
  logic [9:0]  lo_ns;
  logic [13:0] q[$];
  logic [13:0] s;
  logic [13:0] n;
  logic [12:0] e;
  int          r;
  int          skip;
  int          cyc;
  int          n_valid;
  int          n_mismatch;
  int          n_compared;

  aeo_top dut
  (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .encode_clock_pos  (enc),
    .mode_sel          (mode_sel),
    .conv_raw          (conv_raw),
    .conv_over         (conv_over),
    .conv_under        (conv_under),
    .sample_code_bits  (code),
    .out_of_range_flag (flag),
    .sample_valid      (vld),
    .internal_clock    (iclk),
    .stabilizer_on     (stab)
  );

  aeo_enc_src src
  (
    .run   (run),
    .hi_ns (hi_ns),
    .lo_ns (lo_ns),
    .enc   (enc)
  );

  always #25 clk_sys = ~clk_sys;

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Note is {under, over, raw}; result is {flag, code}
  function automatic logic [12:0] expect_f(input logic [13:0] v, input logic tw);
    if (v[13])
      return {1'b1, tw ? TC_MIN : OB_MIN};
    if (v[12])
      return {1'b1, tw ? TC_MAX : OB_MAX};
    return {1'b0, tw ? v[11:0] ^ SIGN_FLIP : v[11:0]};
  endfunction

  task automatic rises(input int k);
    repeat (k) @(posedge enc);
    repeat (7) @(posedge clk_sys);
  endtask

  task automatic restart(input logic [1:0] m, input logic [9:0] h, input logic [9:0] l);
    run <= 1'b0;
    repeat (300) @(posedge clk_sys);
    mode_sel <= m;
    hi_ns <= h;
    lo_ns <= l;
    skip <= 6;
    @(posedge clk_sys);
    run <= 1'b1;
  endtask

  // New input in the low phase, noted for the capture at the next rise
  always @(posedge enc)
  begin
    repeat (6) @(posedge clk_sys);
    r = $urandom % 8;
    s = {r == 1, r == 0, r == 2 ? OB_MAX : r == 3 ? OB_MIN : r == 4 ? OB_ZERO : 12'($urandom)};
    conv_under <= s[13];
    conv_over <= s[12];
    conv_raw <= s[11:0];
    q.push_back(s);
  end

  // Output of a rise belongs to the capture five rises earlier
  always @(posedge enc)
  begin
    repeat (5) @(posedge clk_sys);
    check(12'(stab), 12'(mode_sel == MODE_THR1 || mode_sel == MODE_THR2));
    if (q.size() >= 6)
    begin
      n = q.pop_front();
      e = expect_f(n, mode_sel[1]);
      if (skip > 0)
        skip--;
      else if (vld === 1'b1)
      begin
        n_valid++;
        check(code, e[11:0]);
        check(12'(flag), 12'(e[12]));
      end
    end
    // Internal clock high for half of the ten-cycle period; pin duty 40% only with the stabilizer on, else 50%
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    if (skip == 0)
      check(12'(iclk), 12'h0_001);
    @(negedge clk_sys);
    if (skip == 0)
      check(12'(iclk), 12'h0_000);
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial
  begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    run = 1'b0;
    mode_sel = MODE_GND;
    hi_ns = 10'd250;
    lo_ns = 10'd250;
    conv_raw = OB_ZERO;
    conv_over = 1'b0;
    conv_under = 1'b0;
    skip = 0;
    cyc = 0;
    n_valid = 0;
    n_mismatch = 0;
    n_compared = 0;
    q.push_back({2'b00, OB_ZERO});
    r = $urandom(1);
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    run <= 1'b1;
    rises(40);
    mode_sel <= MODE_VDD;
    skip <= 6;
    rises(40);
    restart(MODE_THR1, 10'd200, 10'd300);
    rises(50);
    check(12'(vld), 12'h0_000);
    rises(70);
    check(12'(vld), 12'h0_001);
    mode_sel <= MODE_THR2;
    skip <= 6;
    rises(40);
    restart(MODE_GND, 10'd250, 10'd250);
    rises(20);
    check(12'(vld), 12'h0_001);
    check(12'(n_valid > 100), 12'h0_001);
    end_of_test();
  end
endmodule

// >>> verification/aeo_enc_src.sv
`timescale 1ns/1ps
module aeo_enc_src
(
  // Control
  input  wire logic       run,
  input  wire logic [9:0] hi_ns,
  input  wire logic [9:0] lo_ns,
  // Encode pin
  output logic            enc
);
  // Low phase first; the clock rests low while stopped
  // Small offset keeps pin edges clear of system clock edges
  initial
  begin
    enc = 1'b0;
    forever
    begin
      wait (run);
      #3;
      while (run)
      begin
        #(lo_ns);
        enc = 1'b1;
        #(hi_ns);
        enc = 1'b0;
      end
    end
  end
endmodule
